/* rtl/lwb_adaptor.sv */
// adaptor end: address map, fifteen buffered paths and the
// random access sequencer toward the system backplane.
// assumes the backplane port holds ack for one cycle per request and
// the peripheral holds req until ack or its own timeout.
`timescale 1ns/1ps
module lwb_adaptor #(
  parameter int MAP_AW = lwb_pkg::MAP_AW
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic init,
  lwb_unibus_if.adaptor ub,
  input wire logic map_we,
  input wire logic [MAP_AW-1:0] map_idx,
  input wire logic [31:0] map_wdata,
  output logic [31:0] map_rdata_q,
  output logic sb_req_q,
  output logic sb_we_q,
  output logic [lwb_pkg::SB_ADDR_W-1:0] sb_addr_q,
  output logic [31:0] sb_wdata_q,
  output logic [3:0] sb_mask_q,
  input wire logic sb_ack,
  input wire logic sb_err,
  input wire logic [31:0] sb_rdata
);

  localparam int MAP_ENTRIES = 2 ** MAP_AW;
  localparam int NP = lwb_pkg::NUM_PATHS;

  typedef enum logic [2:0] {
    S_IDLE = 3'b000,
    S_EVAL = 3'b001,
    S_RD = 3'b010,
    S_WRISS = 3'b011,
    S_WR = 3'b100,
    S_ACK = 3'b101,
    S_DROP = 3'b110
  } lwb_state_e;

  lwb_state_e state_q;
  logic [31:0] map_q [MAP_ENTRIES];
  lwb_pkg::lwb_func_e func_q;
  logic [17:0] addr_q;
  logic [15:0] wdata_q;
  logic [31:0] entry_q;
  logic [15:0] rdata_q;

  logic [lwb_pkg::DESIG_W-1:0] sel;
  logic lw_mode;
  logic high;
  logic [31:0] p_data [NP+1];
  logic [3:0] p_mask [NP+1];
  logic p_full [NP+1];
  logic cur_full;
  logic st_en;
  logic [3:0] st_be;
  logic ld_en;
  logic set_full;
  logic clr_full;
  logic clr_mask;
  logic wr_trig;

  ////////////////////////////////////////////////////////////////////
  // address map

  for (genvar e = 0; e < MAP_ENTRIES; e++) begin : g_map
    always_ff @(posedge clk) begin
      if (reset) begin
        map_q[e] <= lwb_pkg::MAP_RESET;
      end else begin
        if (map_we && map_idx == MAP_AW'(e)) begin
          map_q[e] <= map_wdata;
        end
        if (init) begin
          map_q[e][lwb_pkg::LONGWORD_ACCESS_ENABLE_BIT] <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      map_rdata_q <= 32'h0000_0000;
    end else begin
      map_rdata_q <= map_q[map_idx];
    end
  end

  ////////////////////////////////////////////////////////////////////
  // decode of the latched request

  assign sel = entry_q[lwb_pkg::DESIG_LSB +: lwb_pkg::DESIG_W];
  // a direct path (designator 0) never enters this mode
  assign lw_mode = entry_q[lwb_pkg::MAP_VALID_BIT] &&
                   entry_q[lwb_pkg::LONGWORD_ACCESS_ENABLE_BIT] && (sel != 4'h0);
  assign high = addr_q[1];
  assign cur_full = p_full[sel];
  assign wr_trig = (func_q == lwb_pkg::FN_DATO && high) ||
                   (func_q == lwb_pkg::FN_DATOB && addr_q[1:0] == 2'b11);

  always_comb begin
    st_en = 1'b0;
    st_be = 4'h0;
    ld_en = 1'b0;
    set_full = 1'b0;
    clr_full = 1'b0;
    clr_mask = 1'b0;
    unique case (state_q)
      S_EVAL: begin
        if (lw_mode && (func_q == lwb_pkg::FN_DATO ||
                        func_q == lwb_pkg::FN_DATOB)) begin
          st_en = 1'b1;
          if (func_q == lwb_pkg::FN_DATO) begin
            st_be = high ? 4'b1100 : 4'b0011;
          end else begin
            st_be = 4'b0001 << addr_q[1:0];
          end
          set_full = !wr_trig;
        end else if (lw_mode && func_q == lwb_pkg::FN_DATI &&
                     cur_full && high) begin
          clr_full = 1'b1;
        end
      end
      S_RD: begin
        // only a good low-word read fills the buffer
        ld_en = sb_ack && !sb_err && !high;
        set_full = ld_en;
      end
      S_WR: begin
        clr_full = sb_ack;
        clr_mask = sb_ack;
      end
      S_IDLE, S_WRISS, S_ACK, S_DROP: begin
      end
      default: begin
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////
  // buffered paths, one state each

  assign p_data[0] = 32'h0000_0000;
  assign p_mask[0] = 4'h0;
  assign p_full[0] = 1'b0;

  for (genvar p = 1; p <= NP; p++) begin : g_path
    logic hit;
    assign hit = (sel == lwb_pkg::DESIG_W'(p));
    lwb_path u_path (
      .clk(clk),
      .reset(reset),
      .init(init),
      .st_en(st_en && hit),
      .st_be(st_be),
      .st_data({wdata_q, wdata_q}),
      .ld_en(ld_en && hit),
      .ld_data(sb_rdata),
      .set_full(set_full && hit),
      .clr_full(clr_full && hit),
      .clr_mask(clr_mask && hit),
      .data_q(p_data[p]),
      .mask_q(p_mask[p]),
      .full_q(p_full[p])
    );
  end

  ////////////////////////////////////////////////////////////////////
  // sequencer

  always_ff @(posedge clk) begin
    if (reset) begin
      state_q <= S_IDLE;
    end else begin
      unique case (state_q)
        S_IDLE: begin
          if (ub.req) begin
            state_q <= S_EVAL;
          end
        end
        S_EVAL: begin
          if (!lw_mode || func_q == lwb_pkg::FN_DATIP) begin
            state_q <= S_DROP;
          end else if (func_q == lwb_pkg::FN_DATI) begin
            // an occupied buffer never goes to memory and is served with no address
            // check, so after a low read the next read must be its high word
            state_q <= cur_full ? S_ACK : S_RD;
          end else begin
            state_q <= wr_trig ? S_WRISS : S_ACK;
          end
        end
        S_RD: begin
          if (sb_ack) begin
            state_q <= sb_err ? S_DROP : S_ACK;
          end
        end
        S_WRISS: begin
          state_q <= S_WR;
        end
        S_WR: begin
          if (sb_ack) begin
            state_q <= S_ACK;
          end
        end
        S_ACK, S_DROP: begin
          if (!ub.req) begin
            state_q <= S_IDLE;
          end
        end
        default: begin
          state_q <= S_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      func_q <= lwb_pkg::FN_DATI;
      addr_q <= 18'h0_0000;
      wdata_q <= 16'h0000;
      entry_q <= 32'h0000_0000;
    end else if (state_q == S_IDLE && ub.req) begin
      func_q <= ub.func;
      addr_q <= ub.addr;
      wdata_q <= ub.wdata;
      entry_q <= map_q[ub.addr[lwb_pkg::PAGE_LSB +: MAP_AW]];
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      rdata_q <= 16'h0000;
    end else if (state_q == S_EVAL && cur_full) begin
      rdata_q <= high ? p_data[sel][31:16] : p_data[sel][15:0];
    end else if (state_q == S_RD && sb_ack) begin
      rdata_q <= high ? sb_rdata[31:16] : sb_rdata[15:0];
    end
  end

  assign ub.rdata = rdata_q;
  assign ub.ack = (state_q == S_ACK);

  ////////////////////////////////////////////////////////////////////
  // backplane port

  always_ff @(posedge clk) begin
    if (reset) begin
      sb_req_q <= 1'b0;
      sb_we_q <= 1'b0;
    end else if (state_q == S_EVAL && lw_mode &&
                 func_q == lwb_pkg::FN_DATI && !cur_full) begin
      sb_req_q <= 1'b1;
      sb_we_q <= 1'b0;
    end else if (state_q == S_WRISS) begin
      sb_req_q <= 1'b1;
      sb_we_q <= 1'b1;
    end else if (sb_ack) begin
      sb_req_q <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      sb_addr_q <= 28'h000_0000;
      sb_wdata_q <= 32'h0000_0000;
      sb_mask_q <= 4'h0;
    end else if (state_q == S_EVAL) begin
      sb_addr_q <= {entry_q[lwb_pkg::PFN_LSB +: lwb_pkg::PFN_W],
                    addr_q[lwb_pkg::LW_LSB +: lwb_pkg::LW_IN_PAGE_W]};
    end else if (state_q == S_WRISS) begin
      // the buffer already holds the last stored word here
      sb_wdata_q <= p_data[sel];
      sb_mask_q <= p_mask[sel];
    end
  end

endmodule

/* rtl/lwb_path.sv */
// one buffered data path: longword store, byte mask, occupied flag.
// assumes the adaptor never loads and stores in the same cycle.
`timescale 1ns/1ps
module lwb_path (
  input wire logic clk,
  input wire logic reset,
  input wire logic init,
  input wire logic st_en,
  input wire logic [3:0] st_be,
  input wire logic [31:0] st_data,
  input wire logic ld_en,
  input wire logic [31:0] ld_data,
  input wire logic set_full,
  input wire logic clr_full,
  input wire logic clr_mask,
  output logic [31:0] data_q,
  output logic [3:0] mask_q,
  output logic full_q
);

  always_ff @(posedge clk) begin
    if (ld_en) begin
      data_q <= ld_data;
    end else if (st_en) begin
      for (int b = 0; b < 4; b++) begin
        if (st_be[b]) begin
          data_q[8*b +: 8] <= st_data[8*b +: 8];
        end
      end
    end
  end

  // mask survives the flag clear of a high read, so a read-modify-write
  // still writes back the low word stored before that read
  always_ff @(posedge clk) begin
    if (reset || init || clr_mask) begin
      mask_q <= 4'h0;
    end else if (st_en) begin
      mask_q <= mask_q | st_be;
    end
  end

  always_ff @(posedge clk) begin
    if (reset || init || clr_full) begin
      full_q <= 1'b0;
    end else if (set_full) begin
      full_q <= 1'b1;
    end
  end

endmodule

/* rtl/lwb_peripheral.sv */
// peripheral end: turns user commands into interlocked bus cycles,
// times out a missing slave reply, and refuses out-of-order use.
// assumes the adaptor drops ack once req is released.
`timescale 1ns/1ps
module lwb_peripheral (
  input wire logic clk,
  input wire logic reset,
  lwb_unibus_if.peripheral ub,
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire lwb_pkg::lwb_func_e cmd_func,
  input wire logic [17:0] cmd_addr,
  input wire logic [15:0] cmd_wdata,
  output logic resp_valid_q,
  output logic [15:0] resp_rdata_q,
  output logic resp_nxm_q,
  output logic resp_refused_q
);

  typedef enum logic [1:0] {
    H_IDLE = 2'b00,
    H_WAIT = 2'b01,
    H_REL = 2'b10
  } lwb_hstate_e;

  localparam logic [10:0] TMO_LAST =
    11'(lwb_pkg::SSYN_TIMEOUT_CYC - 1);

  lwb_hstate_e state_q;
  logic req_q;
  lwb_pkg::lwb_func_e func_q;
  logic [17:0] addr_q;
  logic [15:0] wdata_q;
  logic [lwb_pkg::TMR_W-1:0] tmr_q;
  logic nxm_q;
  logic [15:0] lw_q;
  logic low_seen_q;
  logic refuse;
  logic take;

  ////////////////////////////////////////////////////////////////////
  // ordering guard

  // a high word is legal only after a low word of the same longword
  assign refuse = (cmd_func == lwb_pkg::FN_DATIP) ||
                  (cmd_addr[1] &&
                   !(low_seen_q && lw_q == cmd_addr[17:2]));
  assign cmd_ready = (state_q == H_IDLE);
  assign take = cmd_valid && cmd_ready;

  always_ff @(posedge clk) begin
    if (reset) begin
      lw_q <= 16'h0000;
      low_seen_q <= 1'b0;
    end else if (take && !refuse && !cmd_addr[1]) begin
      lw_q <= cmd_addr[17:2];
      low_seen_q <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // bus cycle

  always_ff @(posedge clk) begin
    if (reset) begin
      state_q <= H_IDLE;
      req_q <= 1'b0;
      tmr_q <= 11'h000;
      nxm_q <= 1'b0;
    end else begin
      unique case (state_q)
        H_IDLE: begin
          if (take && !refuse) begin
            req_q <= 1'b1;
            tmr_q <= 11'h000;
            nxm_q <= 1'b0;
            state_q <= H_WAIT;
          end
        end
        H_WAIT: begin
          if (ub.ack) begin
            req_q <= 1'b0;
            state_q <= H_REL;
          end else if (tmr_q == TMO_LAST) begin
            // no slave reply: nonexistent memory
            req_q <= 1'b0;
            nxm_q <= 1'b1;
            state_q <= H_REL;
          end else begin
            tmr_q <= tmr_q + 11'h001;
          end
        end
        H_REL: begin
          if (!ub.ack) begin
            state_q <= H_IDLE;
          end
        end
        default: begin
          state_q <= H_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      func_q <= lwb_pkg::FN_DATI;
      addr_q <= 18'h0_0000;
      wdata_q <= 16'h0000;
    end else if (take && !refuse) begin
      func_q <= cmd_func;
      addr_q <= cmd_addr;
      wdata_q <= cmd_wdata;
    end
  end

  assign ub.req = req_q;
  assign ub.func = func_q;
  assign ub.addr = addr_q;
  assign ub.wdata = wdata_q;

  ////////////////////////////////////////////////////////////////////
  // response

  always_ff @(posedge clk) begin
    if (reset) begin
      resp_valid_q <= 1'b0;
      resp_rdata_q <= 16'h0000;
      resp_nxm_q <= 1'b0;
      resp_refused_q <= 1'b0;
    end else begin
      resp_valid_q <= 1'b0;
      if (take && refuse) begin
        resp_valid_q <= 1'b1;
        resp_refused_q <= 1'b1;
        resp_nxm_q <= 1'b0;
      end else if (state_q == H_REL && !ub.ack) begin
        resp_valid_q <= 1'b1;
        resp_refused_q <= 1'b0;
        resp_nxm_q <= nxm_q;
      end
      if (state_q == H_WAIT && ub.ack) begin
        resp_rdata_q <= ub.rdata;
      end
    end
  end

endmodule

/* rtl/lwb_pkg.sv */
// constants, field layout and types shared by both ends of the
// longword random access buffered path bridge.
// assumes one 100 MHz clock and a synchronous active high reset.
// Notes on behaviour
// - random access needs longword_access_enable set and nonzero path
// - longword_access_enable bit read/write, cleared on adaptor init
// - read-pause cycle gets no reply, flag unchanged
// - no prefetch of the following longword
// - empty low read: backplane read, store, flag
// - empty high read: backplane read, flag stays clear
// - occupied read served from buffer, high clears
// - writes store data, set mask, set flag (a write that triggers a backplane write leaves the flag unset)
// - high word or byte 3 write triggers backplane write
// - backplane write touches only masked bytes
// - peripheral accesses low word before high word
// - peripheral avoids read-pause, keeps longword alignment
// - software sets valid, clears shift, path 1-15
// - page frame field gives backplane page address
// - no purge needed after ordered transfers
// - read-modify-write: read, buffer, buffer, write back
package lwb_pkg;

  // map entry layout
  localparam int MAP_VALID_BIT = 31;
  localparam int LONGWORD_ACCESS_ENABLE_BIT = 26;
  localparam int BSEL_BIT = 25;
  localparam int DESIG_LSB = 21;
  localparam int DESIG_W = 4;
  localparam int PFN_LSB = 0;
  localparam int PFN_W = 21;
  localparam logic [31:0] MAP_RESET = 32'h0000_0000;

  // peripheral address layout
  localparam int UADDR_W = 18;
  localparam int PAGE_LSB = 9;
  localparam int MAP_AW = 9;
  localparam int LW_LSB = 2;
  localparam int LW_IN_PAGE_W = 7;
  localparam int SB_ADDR_W = 28;

  localparam int NUM_PATHS = 15;

  // slave-sync timeout seen by the peripheral
  localparam int CLK_PERIOD_NS = 10;
  localparam int SSYN_TIMEOUT_NS = 10000;
  localparam int SSYN_TIMEOUT_CYC =
    (SSYN_TIMEOUT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TMR_W = 11;

  typedef enum logic [1:0] {
    FN_DATI = 2'b00,
    FN_DATIP = 2'b01,
    FN_DATO = 2'b10,
    FN_DATOB = 2'b11
  } lwb_func_e;

endpackage

/* rtl/lwb_unibus_if.sv */
// peripheral-side bus between the dma peripheral and the adaptor.
// assumes both ends run on the same clock; req/ack is a full
// interlock: req holds until ack rises or the peripheral times out.
`timescale 1ns/1ps
interface lwb_unibus_if;
  logic req;
  lwb_pkg::lwb_func_e func;
  logic [17:0] addr;
  logic [15:0] wdata;
  logic [15:0] rdata;
  logic ack;

  modport adaptor (
    input req,
    input func,
    input addr,
    input wdata,
    output rdata,
    output ack
  );

  modport peripheral (
    output req,
    output func,
    output addr,
    output wdata,
    input rdata,
    input ack
  );
endinterface

/* verification/longword_random_access_bdp_bench.sv */
// bench: peripheral end and adaptor end on one bus, a behavioural
// backplane memory, and a second adaptor fed misuse directly.
// assumes the rtl/ files are compiled first.
`timescale 1ns/1ps
module longword_random_access_bdp_bench;
  logic clk, reset, init, map_we, cmd_valid, cmd_ready, err_next;
  logic sb_req_q, sb_we_q, sb_ack, sb_err, r_nxm, r_ref, go;
  logic resp_valid_q, resp_nxm_q, resp_refused_q;
  logic [8:0] map_idx;
  logic [27:0] sb_addr_q;
  logic [31:0] map_wdata, map_rdata_q, sb_wdata_q, sb_rdata, e0, e1, wm;
  logic [3:0] sb_mask_q;
  logic [17:0] cmd_addr;
  logic [15:0] cmd_wdata, resp_rdata_q, r_data, d;
  lwb_pkg::lwb_func_e cmd_func;
  logic [31:0] mem [logic [27:0]];
  logic [20:0] page_frame_field [0:5];
  integer seed = 32'h0000_29c8;
  int fail_count, total_checks, sb_rd, sb_wr, rd0, wr0, k, w;
  lwb_unibus_if ub();
  lwb_unibus_if ub2();

  lwb_adaptor lwb_adaptor_inst (.clk(clk), .reset(reset), .init(init),
    .ub(ub.adaptor), .map_we(map_we), .map_idx(map_idx),
    .map_wdata(map_wdata), .map_rdata_q(map_rdata_q), .sb_req_q(sb_req_q),
    .sb_we_q(sb_we_q), .sb_addr_q(sb_addr_q), .sb_wdata_q(sb_wdata_q),
    .sb_mask_q(sb_mask_q), .sb_ack(sb_ack), .sb_err(sb_err),
    .sb_rdata(sb_rdata));
  // second adaptor only sees read-pause misuse; backplane never answers
  lwb_adaptor lwb_adaptor_inst_b (.clk(clk), .reset(reset), .init(init),
    .ub(ub2.adaptor), .map_we(map_we), .map_idx(map_idx),
    .map_wdata(map_wdata), .map_rdata_q(), .sb_req_q(), .sb_we_q(),
    .sb_addr_q(), .sb_wdata_q(), .sb_mask_q(), .sb_ack(1'h0),
    .sb_err(1'h0), .sb_rdata(32'h0000_0000));
  lwb_peripheral lwb_peripheral_inst (.clk(clk), .reset(reset),
    .ub(ub.peripheral), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
    .cmd_func(cmd_func), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata),
    .resp_valid_q(resp_valid_q), .resp_rdata_q(resp_rdata_q),
    .resp_nxm_q(resp_nxm_q), .resp_refused_q(resp_refused_q));
  lwb_asserts lwb_asserts_inst (.clk(clk), .reset(reset), .req(ub.req),
    .func(ub.func), .addr(ub.addr), .wdata(ub.wdata), .rdata(ub.rdata),
    .ack(ub.ack));

  ////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] rd_mem(logic [27:0] a);
    return mem.exists(a) ? mem[a] : {a[15:0], ~a[15:0]};
  endfunction
  function automatic logic [17:0] ua(int i, int lw, int b);
    return {i[8:0], lw[6:0], b[1:0]};
  endfunction
  function automatic logic [27:0] sa(int i, int lw);
    return {page_frame_field[i], lw[6:0]};
  endfunction
  // entry 3 uses path 15, entry 4 has enable clear, entry 5 path 0
  function automatic logic [31:0] ment(logic lw, int i);
    return {1'h1, 4'h0, lw, 1'h0, 4'(i == 3 ? 15 : i == 5 ? 0 : i + 1),
      page_frame_field[i]};
  endfunction

  task automatic check_val(string what, logic [31:0] exp, logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask
  task automatic check_resp(logic nxm, logic refused);
    total_checks++;
    if ({r_nxm, r_ref} !== {nxm, refused}) begin
      fail_count++;
      $display("unexpected response flags: expected %b, seen %b",
        {nxm, refused}, {r_nxm, r_ref});
    end
  endtask
  task automatic cmd(lwb_pkg::lwb_func_e f, logic [17:0] a, logic [15:0] v);
    int n;
    @(negedge clk);
    cmd_valid = 1'h1;
    cmd_func = f;
    cmd_addr = a;
    cmd_wdata = v;
    n = 0;
    while (cmd_ready !== 1'h1) @(negedge clk);
    @(negedge clk);
    cmd_valid = 1'h0;
    while (resp_valid_q !== 1'h1 && n < 1100) begin
      @(negedge clk);
      n++;
    end
    if (n >= 1100) begin
      fail_count++;
      $display("unexpected response: expected pulse, seen none");
    end
    r_data = resp_rdata_q;
    r_nxm = resp_nxm_q;
    r_ref = resp_refused_q;
  endtask
  task automatic map_wr(int i, logic [31:0] v);
    @(negedge clk);
    map_we = 1'h1;
    map_idx = 9'(i);
    map_wdata = v;
    @(negedge clk);
    map_we = 1'h0;
  endtask
  task automatic map_chk(int i, logic [31:0] v);
    @(negedge clk);
    map_idx = 9'(i);
    repeat (2) @(negedge clk);
    check_val("map entry", v, map_rdata_q);
  endtask
  task automatic wr_bytes(int i, int lw, logic [3:0] m, ref logic [31:0] e);
    for (int b = 0; b < 4; b++)
      if (m[b]) begin
        d = 16'($random(seed));
        cmd(lwb_pkg::FN_DATOB, ua(i, lw, b), d);
        e[8*b +: 8] = b[0] ? d[15:8] : d[7:0];
      end
  endtask
  task automatic print_verdict();
    $display("checks %0d, mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////
  // backplane memory: random answer delay, line scrambled between replies
  always @(negedge clk) begin
    wm = $random(seed);
    go = sb_req_q && !sb_ack && $random(seed) % 2 == 0;
    if (go) begin
      wm = rd_mem(sb_addr_q);
      if (sb_we_q) begin
        for (int b = 0; b < 4; b++)
          if (sb_mask_q[b]) wm[8*b +: 8] = sb_wdata_q[8*b +: 8];
        mem[sb_addr_q] = wm;
        sb_wr++;
      end else begin
        sb_rd++;
      end
    end
    sb_ack <= go;
    sb_err <= go && !sb_we_q && err_next;
    sb_rdata <= wm;
  end

  initial begin
    clk = 1'h0;
    forever #5 clk = ~clk;
  end
  initial begin
    #400000;
    fail_count++;
    $display("unexpected run time: expected finish, seen hang");
    print_verdict();
  end

  initial begin
    reset = 1'h1;
    {init, map_we, cmd_valid, err_next} = '0;
    {map_idx, map_wdata, cmd_addr, cmd_wdata} = '0;
    cmd_func = lwb_pkg::FN_DATI;
    {ub2.req, ub2.addr, ub2.wdata} = '0;
    ub2.func = lwb_pkg::FN_DATIP;
    for (int i = 0; i < 6; i++) page_frame_field[i] = 21'($random(seed));
    repeat (4) @(negedge clk);
    reset = 1'h0;
    for (int i = 0; i < 6; i++) map_wr(i, ment(i != 4, i));
    map_chk(3, ment(1'h1, 3));
    @(negedge clk);
    init = 1'h1;
    @(negedge clk);
    init = 1'h0;
    map_chk(3, ment(1'h0, 3));
    for (int i = 0; i < 6; i++) map_wr(i, ment(i != 4, i));
    $display("test map done");
    rd0 = sb_rd;
    for (int n = 0; n < 6; n++) begin
      k = n % 4;
      w = $random(seed);
      e0 = rd_mem(sa(k, w));
      cmd(lwb_pkg::FN_DATI, ua(k, w, 0), 16'h0000);
      check_val("low word", e0[15:0], r_data);
      cmd(lwb_pkg::FN_DATI, ua(k, w, 2), 16'h0000);
      check_val("high word", e0[31:16], r_data);
    end
    check_val("backplane reads", rd0 + 6, sb_rd);
    for (int n = 0; n < 3; n++) begin
      w = $random(seed);
      e0 = $random(seed);
      wr0 = sb_wr;
      cmd(lwb_pkg::FN_DATO, ua(n, w, 0), e0[15:0]);
      cmd(lwb_pkg::FN_DATO, ua(n, w, 2), e0[31:16]);
      check_val("written longword", e0, rd_mem(sa(n, w)));
      check_val("word writes", wr0 + 1, sb_wr);
    end
    for (int s = 0; s < 3; s++) begin
      w = $random(seed);
      e0 = rd_mem(sa(2, w));
      wr0 = sb_wr;
      wr_bytes(2, w, 4'hf & ~(4'h1 << s), e0);
      check_val("masked longword", e0, rd_mem(sa(2, w)));
      check_val("byte writes", wr0 + 1, sb_wr);
    end
    w = $random(seed);
    e0 = rd_mem(sa(0, w));
    e1 = rd_mem(sa(1, w));
    wr_bytes(0, w, 4'h1, e0);
    wr_bytes(1, w, 4'ha, e1);
    wr_bytes(0, w, 4'h9, e0);
    check_val("first path", e0, rd_mem(sa(0, w)));
    check_val("second path", e1, rd_mem(sa(1, w)));
    $display("test writes done");
    w = $random(seed);
    e0 = rd_mem(sa(3, w));
    {rd0, wr0} = {sb_rd, sb_wr};
    cmd(lwb_pkg::FN_DATI, ua(3, w, 0), 16'h0000);
    check_val("rmw low", e0[15:0], r_data);
    e0[15:0] = 16'($random(seed));
    cmd(lwb_pkg::FN_DATO, ua(3, w, 0), e0[15:0]);
    cmd(lwb_pkg::FN_DATI, ua(3, w, 2), 16'h0000);
    check_val("rmw high", e0[31:16], r_data);
    e0[31:16] = 16'($random(seed));
    cmd(lwb_pkg::FN_DATO, ua(3, w, 2), e0[31:16]);
    check_val("rmw longword", e0, rd_mem(sa(3, w)));
    check_val("rmw traffic", rd0 + wr0 + 2, sb_rd + sb_wr);
    rd0 = sb_rd;
    repeat (2) begin
      cmd(lwb_pkg::FN_DATI, ua(3, w, 2), 16'h0000);
      check_val("empty high read", e0[31:16], r_data);
    end
    check_val("high reads", rd0 + 2, sb_rd);
    $display("test rmw done");
    err_next = 1'h1;
    rd0 = sb_rd;
    e0 = rd_mem(sa(0, w));
    cmd(lwb_pkg::FN_DATI, ua(0, w, 0), 16'h0000);
    err_next = 1'h0;
    check_resp(1'h1, 1'h0);
    cmd(lwb_pkg::FN_DATI, ua(0, w, 2), 16'h0000);
    check_val("high after failed read", e0[31:16], r_data);
    check_val("reads after failure", rd0 + 2, sb_rd);
    cmd(lwb_pkg::FN_DATI, ua(4, w, 0), 16'h0000);
    check_resp(1'h1, 1'h0);
    cmd(lwb_pkg::FN_DATO, ua(5, w, 0), 16'h0000);
    check_resp(1'h1, 1'h0);
    cmd(lwb_pkg::FN_DATIP, ua(0, w, 0), 16'h0000);
    check_resp(1'h0, 1'h1);
    cmd(lwb_pkg::FN_DATI, ua(1, w, 2), 16'h0000);
    check_resp(1'h0, 1'h1);
    ub2.addr = ua(0, w, 0);
    ub2.req = 1'h1;
    r_nxm = 1'h0;
    repeat (1000) begin
      @(negedge clk);
      r_nxm = r_nxm | ub2.ack;
    end
    ub2.req = 1'h0;
    check_val("read-pause reply", 32'h0000_0000, r_nxm);
    $display("test refusals done");
    print_verdict();
  end
endmodule

/* verification/lwb_asserts.sv */
// assertions on the bus joining the peripheral end to the adaptor end.
// assumes clk and reset are the ones both ends run on.
`timescale 1ns/1ps
module lwb_asserts (
  input wire logic clk,
  input wire logic reset,
  input wire logic req,
  input wire lwb_pkg::lwb_func_e func,
  input wire logic [17:0] addr,
  input wire logic [15:0] wdata,
  input wire logic [15:0] rdata,
  input wire logic ack
);
  localparam int WAIT_MAX = lwb_pkg::SSYN_TIMEOUT_CYC + 2;
  logic low_seen_q;
  logic [15:0] low_lw_q;
  logic [10:0] wait_q;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);

  ////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk) begin
    if (reset) begin
      low_seen_q <= 1'h0;
    end else if ($rose(req) && !addr[1]) begin
      low_seen_q <= 1'h1;
    end
  end
  always_ff @(posedge clk) begin
    if ($rose(req) && !addr[1]) begin
      low_lw_q <= addr[17:2];
    end
  end
  // unanswered request age; the peripheral must give up on its own
  always_ff @(posedge clk) begin
    if (reset || !req || ack) begin
      wait_q <= 11'h000;
    end else begin
      wait_q <= wait_q + 11'h001;
    end
  end

  ////////////////////////////////////////////////////////////////////
  sequence s_reply;
    req && ack;
  endsequence
  sequence s_release;
    !req ##1 !ack;
  endsequence

  a_handshake_steps: assert property (
    $rose(ack) |-> s_reply ##1 s_release)
    else $error("reply handshake broken");
  a_no_readpause: assert property (
    req |-> func != lwb_pkg::FN_DATIP)
    else $error("read-pause cycle issued");
  a_low_before_high: assert property (
    $rose(req) && addr[1] |-> low_seen_q && low_lw_q == addr[17:2])
    else $error("high word requested without its low word");
  a_cmd_held: assert property (
    req && !ack |=> !req || ($stable(addr) && $stable(func)))
    else $error("request changed before reply");
  a_wdata_held: assert property (
    req && func[1] && !ack |=> !req || $stable(wdata))
    else $error("write data changed before reply");
  a_rdata_held: assert property (
    ack && $past(ack) |-> $stable(rdata))
    else $error("read data changed during reply");
  a_ack_needs_req: assert property (
    ack |-> req || $past(req))
    else $error("reply without request");
  a_wait_bounded: assert property (
    wait_q <= WAIT_MAX)
    else $error("request held past the slave timeout");
endmodule
